// ---- cvc_pkg.sv ----
package cvc_pkg;
  // register offsets (bus address width 8)
  localparam logic [7:0] ADDR_PORT_A_PINS        = 8'h05;
  localparam logic [7:0] ADDR_CORE_IRQ_CONTROL   = 8'h0B;
  localparam logic [7:0] ADDR_PERIPH_FLAGS_TWO   = 8'h0D;
  localparam logic [7:0] ADDR_PORT_A_DIRECTION   = 8'h85;
  localparam logic [7:0] ADDR_PERIPH_ENABLES_TWO = 8'h8D;
  localparam logic [7:0] ADDR_COMPARATOR_CONTROL = 8'h9C;
  localparam logic [7:0] ADDR_LADDER_CONTROL     = 8'h9D;
  localparam logic [7:0] ADDR_IRQ_STATUS         = 8'hA0;
  localparam logic [7:0] ADDR_IRQ_CLEAR          = 8'hA1;
  localparam logic [7:0] ADDR_IRQ_ENABLE         = 8'hA2;
  localparam logic [7:0] ADDR_SLEEP_CONTROL      = 8'hA3;

  // reset values
  localparam logic [7:0] RST_COMPARATOR_CONTROL = 8'h07;
  localparam logic [7:0] RST_LADDER_CONTROL     = 8'h00;
  localparam logic [7:0] RST_CORE_IRQ_CONTROL   = 8'h00;
  localparam logic [7:0] RST_PERIPH_FLAGS_TWO   = 8'h00;
  localparam logic [7:0] RST_PERIPH_ENABLES_TWO = 8'h00;
  localparam logic [7:0] RST_PORT_A_DIRECTION   = 8'hFF;
  localparam logic [7:0] RST_PORT_A_PINS        = 8'h00;

  // field positions
  localparam int BIT_SECOND_RESULT  = 7;
  localparam int BIT_FIRST_RESULT   = 6;
  localparam int BIT_SECOND_INVERT  = 5;
  localparam int BIT_FIRST_INVERT   = 4;
  localparam int BIT_INPUT_SWITCH   = 3;
  localparam int BIT_LADDER_POWER   = 7;
  localparam int BIT_LADDER_PIN     = 6;
  localparam int BIT_LADDER_RANGE   = 5;
  localparam int BIT_LADDER_UNUSED  = 4;
  localparam int BIT_GLOBAL_IRQ_EN  = 7;
  localparam int BIT_PERIPH_IRQ_EN  = 6;
  localparam int BIT_OSC_FAIL       = 7;
  localparam int BIT_CHANGE_FLAG    = 6;
  localparam int BIT_EEPROM_WRITE   = 4;
  localparam int BIT_PIN5_DIRECTION = 5;
  localparam int BIT_SLEEP_REQUEST  = 0;

  // masks of writable and forced bits, mode codes and field widths
  localparam logic [7:0] MASK_CMP_WRITABLE  = 8'h3F;
  localparam logic [7:0] MASK_LADDER        = 8'hEF;
  localparam logic [7:0] MASK_PERIPH_TWO    = 8'hD0;
  localparam logic [7:0] MASK_PIN5_FORCED   = 8'h20;
  localparam logic [2:0] MODE_OFF           = 3'h7;
  localparam logic [2:0] MODE_LADDER_REF    = 3'h2;
  localparam int         MODE_WIDTH         = 3;
  localparam int         TAP_WIDTH          = 4;

  // interrupt status bits
  localparam int EV_CHANGE = 0;
  localparam int EV_WAKE   = 1;
  localparam int EV_COUNT  = 2;

  typedef enum logic [1:0] {
    CVC_RUN   = 2'b00,
    CVC_SLEEP = 2'b01,
    CVC_WAKE  = 2'b11
  } cvc_power_e;
endpackage

// ---- cvc_sync2.sv ----
`timescale 1ns/1ps
`default_nettype none
// two-stage synchroniser for a bundle of asynchronous levels
module cvc_sync2 #(
  parameter int WIDTH = 2
) (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             reset,
  // levels
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage_one;

  always_ff @(posedge clock) begin
    if (reset) begin
      stage_one <= '0;
      sync_out  <= '0;
    end else begin
      stage_one <= async_in;
      sync_out  <= stage_one;
    end
  end
endmodule
`default_nettype wire

// ---- cvc_comparator_control.sv ----
`timescale 1ns/1ps
`default_nettype none
module cvc_comparator_control
  import cvc_pkg::*;
#(
  parameter int ADDR_WIDTH = 8,
  parameter int DATA_WIDTH = 8
) (
  // clock and reset
  input  wire logic                  clock,
  input  wire logic                  reset,
  // register port
  input  wire logic [ADDR_WIDTH-1:0] reg_address,
  input  wire logic [DATA_WIDTH-1:0] reg_write_data,
  input  wire logic                  reg_write,
  input  wire logic                  reg_read,
  output logic      [DATA_WIDTH-1:0] reg_read_data,
  // analog comparator pair
  input  wire logic                  first_comparator_raw,
  input  wire logic                  second_comparator_raw,
  output logic      [2:0]            comparator_mode_code,
  output logic                       input_switch,
  output logic                       comparators_powered,
  // reference ladder
  output logic                       ladder_power_on,
  output logic                       ladder_pin_drive,
  output logic                       ladder_range_select,
  output logic      [3:0]            ladder_tap_code,
  output logic                       ladder_to_comparators,
  // core interrupt and power
  output logic                       core_irq_request,
  output logic                       wake_request,
  output logic                       sleeping,
  output logic                       irq
);
  logic [7:0]     comparator_control;
  logic [7:0]     next_comparator_control;
  logic [7:0]     reference_ladder_control;
  logic [7:0]     core_interrupt_control;
  logic [7:0]     peripheral_flags_two;
  logic [7:0]     peripheral_enables_two;
  logic [7:0]     port_a_direction;
  logic [7:0]     port_a_pins;
  logic [EV_COUNT-1:0] irq_status;
  logic [EV_COUNT-1:0] irq_enable;
  cvc_power_e     power_state;
  cvc_power_e     next_power_state;
  logic [1:0]     raw_sync;
  logic [1:0]     latched_results;
  logic [1:0]     reported;
  logic           mismatch;
  logic           cmp_access;
  logic           sleep_request;

  function automatic logic hit_write(input logic [ADDR_WIDTH-1:0] a);
    return reg_write && (reg_address == a);
  endfunction

  function automatic logic hit_read(input logic [ADDR_WIDTH-1:0] a);
    return reg_read && (reg_address == a);
  endfunction

  // mode field of a comparator control value
  function automatic logic [MODE_WIDTH-1:0] mode_of(input logic [7:0] control);
    return control[MODE_WIDTH-1:0];
  endfunction

  // analog outputs are asynchronous to the core clock
  cvc_sync2 #(
    .WIDTH (2)
  ) u_sync (
    .clock    (clock),
    .reset    (reset),
    .async_in ({second_comparator_raw, first_comparator_raw}),
    .sync_out (raw_sync)
  );

  // polarity applied after synchronisation; result bits follow the invert bits
  always_comb begin
    reported[0] = raw_sync[0] ^ comparator_control[BIT_FIRST_INVERT];
    reported[1] = raw_sync[1] ^ comparator_control[BIT_SECOND_INVERT];
  end

  assign cmp_access = hit_write(ADDR_COMPARATOR_CONTROL) || hit_read(ADDR_COMPARATOR_CONTROL);
  // mismatch holds until software touches the control register or the results return to the latched values
  assign mismatch = (reported != latched_results);

  // result bits always follow the comparators; only the low bits are writable
  always_comb begin
    next_comparator_control = comparator_control;
    if (hit_write(ADDR_COMPARATOR_CONTROL)) begin
      next_comparator_control = (comparator_control & ~MASK_CMP_WRITABLE) |
                                (reg_write_data & MASK_CMP_WRITABLE);
    end
    next_comparator_control[BIT_SECOND_RESULT] = reported[1];
    next_comparator_control[BIT_FIRST_RESULT]  = reported[0];
  end

  // sleep and wake never touch this register
  always_ff @(posedge clock) begin
    if (reset) begin
      comparator_control <= RST_COMPARATOR_CONTROL;
    end else begin
      comparator_control <= next_comparator_control;
    end
  end

  // snapshot of the last seen results; any access to the comparator control register re-arms the change detector
  always_ff @(posedge clock) begin
    if (reset) begin
      latched_results <= '0;
    end else if (cmp_access) begin
      latched_results <= reported;
    end
  end

  // ladder control register, bit 4 unimplemented
  always_ff @(posedge clock) begin
    if (reset) begin
      reference_ladder_control <= RST_LADDER_CONTROL;
    end else if (hit_write(ADDR_LADDER_CONTROL)) begin
      reference_ladder_control <= reg_write_data & MASK_LADDER;
    end
  end

  // global enable in bit 7, peripheral enable in bit 6
  always_ff @(posedge clock) begin
    if (reset) begin
      core_interrupt_control <= RST_CORE_IRQ_CONTROL;
    end else if (hit_write(ADDR_CORE_IRQ_CONTROL)) begin
      core_interrupt_control <= reg_write_data;
    end
  end

  // enables share the layout of the flag register
  always_ff @(posedge clock) begin
    if (reset) begin
      peripheral_enables_two <= RST_PERIPH_ENABLES_TWO;
    end else if (hit_write(ADDR_PERIPH_ENABLES_TWO)) begin
      peripheral_enables_two <= reg_write_data & MASK_PERIPH_TWO;
    end
  end

  // change flag: a live mismatch wins over a software clear
  always_ff @(posedge clock) begin
    if (reset) begin
      peripheral_flags_two <= RST_PERIPH_FLAGS_TWO;
    end else begin
      if (hit_write(ADDR_PERIPH_FLAGS_TWO)) begin
        peripheral_flags_two <= reg_write_data & MASK_PERIPH_TWO;
      end
      if (mismatch) begin
        peripheral_flags_two[BIT_CHANGE_FLAG] <= 1'b1;
      end
    end
  end

  // pin 5 is input only, so its direction bit is stuck at one
  always_ff @(posedge clock) begin
    if (reset) begin
      port_a_direction <= RST_PORT_A_DIRECTION;
    end else if (hit_write(ADDR_PORT_A_DIRECTION)) begin
      port_a_direction <= reg_write_data | MASK_PIN5_FORCED;
    end
  end

  // data latch only; pin behaviour lives outside this block
  always_ff @(posedge clock) begin
    if (reset) begin
      port_a_pins <= RST_PORT_A_PINS;
    end else if (hit_write(ADDR_PORT_A_PINS)) begin
      port_a_pins <= reg_write_data;
    end
  end

  // sleep request register: software asks, an enabled change event wakes
  always_ff @(posedge clock) begin
    if (reset) begin
      sleep_request <= 1'b0;
    end else if (hit_write(ADDR_SLEEP_CONTROL)) begin
      sleep_request <= reg_write_data[BIT_SLEEP_REQUEST];
    end else if (power_state == CVC_WAKE) begin
      sleep_request <= 1'b0;
    end
  end

  always_comb begin
    case (power_state)
      CVC_RUN: begin
        next_power_state = sleep_request ? CVC_SLEEP : CVC_RUN;
      end
      CVC_SLEEP: begin
        // only the comparator enable gates wake; global enables are for vectoring
        if (peripheral_flags_two[BIT_CHANGE_FLAG] &&
            peripheral_enables_two[BIT_CHANGE_FLAG]) begin
          next_power_state = CVC_WAKE;
        end else begin
          next_power_state = CVC_SLEEP;
        end
      end
      CVC_WAKE: begin
        next_power_state = CVC_RUN;
      end
      default: begin
        next_power_state = CVC_RUN;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      power_state <= CVC_RUN;
    end else begin
      power_state <= next_power_state;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      sleeping     <= 1'b0;
      wake_request <= 1'b0;
    end else begin
      sleeping     <= (next_power_state == CVC_SLEEP);
      wake_request <= (next_power_state == CVC_WAKE);
    end
  end

  // interrupt status: sticky, set beats clear
  always_ff @(posedge clock) begin
    if (reset) begin
      irq_status <= '0;
    end else begin
      if (hit_write(ADDR_IRQ_CLEAR)) begin
        irq_status <= irq_status & ~reg_write_data[EV_COUNT-1:0];
      end
      if (mismatch) begin
        irq_status[EV_CHANGE] <= 1'b1;
      end
      if (next_power_state == CVC_WAKE) begin
        irq_status[EV_WAKE] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      irq_enable <= '0;
    end else if (hit_write(ADDR_IRQ_ENABLE)) begin
      irq_enable <= reg_write_data[EV_COUNT-1:0];
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_enable);
    end
  end

  // core request needs all three enables; the flag sets regardless
  always_ff @(posedge clock) begin
    if (reset) begin
      core_irq_request <= 1'b0;
    end else begin
      core_irq_request <= peripheral_flags_two[BIT_CHANGE_FLAG] &&
                          peripheral_enables_two[BIT_CHANGE_FLAG] &&
                          core_interrupt_control[BIT_PERIPH_IRQ_EN] &&
                          core_interrupt_control[BIT_GLOBAL_IRQ_EN];
    end
  end

  // comparator-side controls; no sleep gating, so enabled comparators stay live
  always_ff @(posedge clock) begin
    if (reset) begin
      comparator_mode_code  <= MODE_OFF;
      input_switch          <= 1'b0;
      comparators_powered   <= 1'b0;
      ladder_to_comparators <= 1'b0;
    end else begin
      comparator_mode_code  <= mode_of(comparator_control);
      input_switch          <= comparator_control[BIT_INPUT_SWITCH];
      comparators_powered   <= (mode_of(comparator_control) != MODE_OFF);
      ladder_to_comparators <= (mode_of(comparator_control) == MODE_LADDER_REF);
    end
  end

  // ladder controls follow the ladder register one cycle later
  always_ff @(posedge clock) begin
    if (reset) begin
      ladder_power_on     <= 1'b0;
      ladder_pin_drive    <= 1'b0;
      ladder_range_select <= 1'b0;
      ladder_tap_code     <= '0;
    end else begin
      ladder_power_on     <= reference_ladder_control[BIT_LADDER_POWER];
      ladder_pin_drive    <= reference_ladder_control[BIT_LADDER_PIN];
      // range set: code/24 of source; clear: quarter plus code/32
      ladder_range_select <= reference_ladder_control[BIT_LADDER_RANGE];
      ladder_tap_code     <= reference_ladder_control[TAP_WIDTH-1:0];
    end
  end

  // read data valid the cycle after the strobe, zero otherwise
  always_ff @(posedge clock) begin
    if (reset) begin
      reg_read_data <= '0;
    end else if (reg_read) begin
      case (reg_address)
        ADDR_COMPARATOR_CONTROL: reg_read_data <= comparator_control;
        ADDR_LADDER_CONTROL:     reg_read_data <= reference_ladder_control;
        ADDR_CORE_IRQ_CONTROL:   reg_read_data <= core_interrupt_control;
        ADDR_PERIPH_FLAGS_TWO:   reg_read_data <= peripheral_flags_two;
        ADDR_PERIPH_ENABLES_TWO: reg_read_data <= peripheral_enables_two;
        ADDR_PORT_A_DIRECTION:   reg_read_data <= port_a_direction;
        ADDR_PORT_A_PINS:        reg_read_data <= port_a_pins;
        ADDR_IRQ_STATUS:         reg_read_data <= DATA_WIDTH'(irq_status);
        ADDR_IRQ_ENABLE:         reg_read_data <= DATA_WIDTH'(irq_enable);
        ADDR_SLEEP_CONTROL:      reg_read_data <= DATA_WIDTH'(sleep_request);
        default:                 reg_read_data <= '0;
      endcase
    end else begin
      reg_read_data <= '0;
    end
  end
endmodule
`default_nettype wire

// ---- cvc_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module cvc_checker
  import cvc_pkg::*;
(
  // clock and reset
  input wire logic       clock,
  input wire logic       reset,
  // register port
  input wire logic [7:0] reg_address,
  input wire logic [7:0] reg_write_data,
  input wire logic       reg_write,
  input wire logic       reg_read,
  input wire logic [7:0] reg_read_data,
  // block outputs
  input wire logic [2:0] comparator_mode_code,
  input wire logic       input_switch,
  input wire logic       comparators_powered,
  input wire logic       ladder_power_on,
  input wire logic       ladder_pin_drive,
  input wire logic       ladder_range_select,
  input wire logic [3:0] ladder_tap_code,
  input wire logic       ladder_to_comparators,
  input wire logic       wake_request,
  input wire logic       sleeping,
  input wire logic       core_irq_request
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  sequence s_lad_wr;
    reg_write && reg_address == ADDR_LADDER_CONTROL;
  endsequence
  property p_power;
    s_lad_wr |-> ##2 ladder_power_on == $past(reg_write_data[BIT_LADDER_POWER], 2);
  endproperty
  a_power: assert property (p_power) else $error("ladder power bit not applied");
  property p_pin;
    s_lad_wr |-> ##2 ladder_pin_drive == $past(reg_write_data[BIT_LADDER_PIN], 2);
  endproperty
  a_pin: assert property (p_pin) else $error("ladder pin drive not applied");
  property p_tap;
    s_lad_wr |-> ##2 ladder_range_select == $past(reg_write_data[BIT_LADDER_RANGE], 2)
      && ladder_tap_code == $past(reg_write_data[3:0], 2);
  endproperty
  a_tap: assert property (p_tap) else $error("range or tap not applied");
  property p_bit4;
    reg_read && reg_address == ADDR_LADDER_CONTROL |=> !reg_read_data[BIT_LADDER_UNUSED];
  endproperty
  a_bit4: assert property (p_bit4) else $error("ladder bit 4 read as one");
  property p_dir5;
    reg_read && reg_address == ADDR_PORT_A_DIRECTION |=> reg_read_data[BIT_PIN5_DIRECTION];
  endproperty
  a_dir5: assert property (p_dir5) else $error("pin 5 direction read as zero");
  property p_rst;
    $fell(reset) |-> comparator_mode_code == MODE_OFF && !input_switch && !ladder_power_on;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  // either latency of the derived flags is accepted once the mode has settled
  property p_powered;
    $stable(comparator_mode_code) [*2] |-> comparators_powered == (comparator_mode_code != MODE_OFF);
  endproperty
  a_powered: assert property (p_powered) else $error("powered flag disagrees with mode");
  property p_ladsel;
    $stable(comparator_mode_code) [*2]
      |-> ladder_to_comparators == (comparator_mode_code == MODE_LADDER_REF);
  endproperty
  a_ladsel: assert property (p_ladsel) else $error("ladder routing disagrees with mode");
  property p_wake;
    wake_request |=> !wake_request;
  endproperty
  a_wake: assert property (p_wake) else $error("wake request longer than one cycle");
  property p_hold;
    $fell(sleeping) |-> $stable(comparator_mode_code) && $stable(input_switch);
  endproperty
  a_hold: assert property (p_hold) else $error("control changed on wake");
  c_wake: cover property (wake_request);
  c_irq: cover property (core_irq_request);
  c_ladder: cover property (ladder_to_comparators && ladder_power_on);
  c_sleep: cover property (sleeping && comparators_powered);
endmodule
bind cvc_comparator_control cvc_checker u_checker (.clock, .reset, .reg_address,
  .reg_write_data, .reg_write, .reg_read, .reg_read_data, .comparator_mode_code,
  .input_switch, .comparators_powered, .ladder_power_on, .ladder_pin_drive,
  .ladder_range_select, .ladder_tap_code, .ladder_to_comparators, .wake_request,
  .sleeping, .core_irq_request);
`default_nettype wire

// ---- cvc_analog_pair.sv ----
`timescale 1ns/1ps
`default_nettype none
// analog comparator pair; an unpowered comparator gives a low output
module cvc_analog_pair (
  // commanded input relation, one bit per comparator
  input  wire logic first_level,
  input  wire logic second_level,
  // power from the block
  input  wire logic comparators_powered,
  // results toward the block
  output logic      first_raw,
  output logic      second_raw
);
  // no dependence on sleep: a powered comparator keeps comparing
  assign first_raw  = comparators_powered & first_level;
  assign second_raw = comparators_powered & second_level;
endmodule
`default_nettype wire

// ---- comparator_vref_control_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module comparator_vref_control_tb
  import cvc_pkg::*;
;
  logic       clock = 1'b0;
  logic       reset = 1'b1;
  logic [7:0] reg_address = 8'h00;
  logic [7:0] reg_write_data = 8'h00;
  logic       reg_write = 1'b0;
  logic       reg_read = 1'b0;
  logic       first_level = 1'b0;
  logic       second_level = 1'b0;
  logic       first_raw, second_raw, input_switch, comparators_powered, ladder_power_on;
  logic       ladder_pin_drive, ladder_range_select, ladder_to_comparators;
  logic       core_irq_request, wake_request, sleeping, irq;
  logic [7:0] reg_read_data;
  logic [2:0] comparator_mode_code;
  logic [3:0] ladder_tap_code;
  int         bad_count = 0;
  int         cmp_count = 0;
  int         cycles = 0;
  cvc_comparator_control DUT (.clock, .reset, .reg_address, .reg_write_data, .reg_write,
    .reg_read, .reg_read_data, .first_comparator_raw(first_raw),
    .second_comparator_raw(second_raw), .comparator_mode_code, .input_switch,
    .comparators_powered, .ladder_power_on, .ladder_pin_drive, .ladder_range_select,
    .ladder_tap_code, .ladder_to_comparators, .core_irq_request, .wake_request, .sleeping,
    .irq);
  cvc_analog_pair u_pair (.first_level, .second_level, .comparators_powered, .first_raw,
    .second_raw);
  initial begin
    forever #2.5 clock = ~clock;
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // a hung wait counts against the run
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      bad_count++;
      conclude();
    end
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_write <= 1'b1;
    reg_address <= a;
    reg_write_data <= d;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    reg_read <= 1'b1;
    reg_address <= a;
    @(posedge clock);
    reg_read <= 1'b0;
    #1;
    chk(reg_read_data, exp);
  endtask
  task automatic st(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // touching the control register ends the mismatch before the flags are cleared
  task automatic clear_flags();
    wr(ADDR_COMPARATOR_CONTROL, 8'h02);
    wr(ADDR_PERIPH_FLAGS_TWO, 8'h00);
    wr(ADDR_IRQ_CLEAR, 8'h03);
  endtask
  task automatic t_reset();
    rdc(ADDR_COMPARATOR_CONTROL, RST_COMPARATOR_CONTROL);
    rdc(ADDR_LADDER_CONTROL, 8'h00);
    rdc(ADDR_PORT_A_DIRECTION, 8'hFF);
    rdc(ADDR_PERIPH_FLAGS_TWO, 8'h00);
    rdc(8'h40, 8'h00);
    chk({5'h0, comparator_mode_code}, {5'h0, MODE_OFF});
    $display("test reset done");
  endtask
  task automatic t_ladder();
    logic [7:0] v[4] = '{8'hFF, 8'h2A, 8'h45, 8'h90};
    foreach (v[i]) begin
      wr(ADDR_LADDER_CONTROL, v[i]);
      st(2);
      chk({7'h0, ladder_power_on}, {7'h0, v[i][7]});
      chk({7'h0, ladder_pin_drive}, {7'h0, v[i][6]});
      chk({7'h0, ladder_range_select}, {7'h0, v[i][5]});
      chk({4'h0, ladder_tap_code}, {4'h0, v[i][3:0]});
      rdc(ADDR_LADDER_CONTROL, v[i] & MASK_LADDER);
    end
    wr(ADDR_PORT_A_DIRECTION, 8'h00);
    rdc(ADDR_PORT_A_DIRECTION, MASK_PIN5_FORCED);
    $display("test ladder done");
  endtask
  task automatic t_modes();
    for (int m = 0; m < 8; m++) begin
      wr(ADDR_COMPARATOR_CONTROL, 8'(m));
      st(3);
      chk({5'h0, comparator_mode_code}, 8'(m));
      chk({7'h0, comparators_powered}, {7'h0, m != 7});
      chk({7'h0, ladder_to_comparators}, {7'h0, m == 2});
    end
    wr(ADDR_COMPARATOR_CONTROL, 8'h3A);
    st(6);
    rdc(ADDR_COMPARATOR_CONTROL, 8'hFA);
    chk({7'h0, input_switch}, 8'h01);
    wr(ADDR_COMPARATOR_CONTROL, 8'hC2);
    st(6);
    rdc(ADDR_COMPARATOR_CONTROL, 8'h02);
    $display("test modes done");
  endtask
  task automatic t_change();
    wr(ADDR_PERIPH_ENABLES_TWO, 8'h40);
    wr(ADDR_CORE_IRQ_CONTROL, 8'hC0);
    wr(ADDR_IRQ_ENABLE, 8'h01);
    rdc(ADDR_PERIPH_ENABLES_TWO, 8'h40);
    rdc(ADDR_CORE_IRQ_CONTROL, 8'hC0);
    clear_flags();
    @(posedge clock);
    first_level <= 1'b1;
    st(8);
    rdc(ADDR_PERIPH_FLAGS_TWO, 8'h40);
    chk({7'h0, core_irq_request}, 8'h01);
    chk({7'h0, irq}, 8'h01);
    wr(ADDR_PERIPH_FLAGS_TWO, 8'h00);
    rdc(ADDR_PERIPH_FLAGS_TWO, 8'h40);
    clear_flags();
    rdc(ADDR_PERIPH_FLAGS_TWO, 8'h00);
    chk({7'h0, core_irq_request}, 8'h00);
    chk({7'h0, irq}, 8'h00);
    wr(ADDR_CORE_IRQ_CONTROL, 8'h00);
    wr(ADDR_IRQ_ENABLE, 8'h00);
    @(posedge clock);
    first_level <= 1'b0;
    st(8);
    rdc(ADDR_PERIPH_FLAGS_TWO, 8'h40);
    chk({7'h0, core_irq_request}, 8'h00);
    chk({7'h0, irq}, 8'h00);
    clear_flags();
    wr(ADDR_PERIPH_FLAGS_TWO, 8'h40);
    rdc(ADDR_PERIPH_FLAGS_TWO, 8'h40);
    clear_flags();
    $display("test change done");
  endtask
  task automatic t_sleep();
    wr(ADDR_SLEEP_CONTROL, 8'h01);
    st(2);
    chk({7'h0, sleeping}, 8'h01);
    rdc(ADDR_SLEEP_CONTROL, 8'h01);
    @(posedge clock);
    second_level <= 1'b1;
    for (int i = 0; i < 20 && wake_request !== 1'b1; i++) begin
      st(1);
    end
    chk({7'h0, wake_request}, 8'h01);
    st(2);
    chk({7'h0, sleeping}, 8'h00);
    rdc(ADDR_COMPARATOR_CONTROL, 8'h82);
    rdc(ADDR_IRQ_STATUS, 8'h03);
    rdc(ADDR_SLEEP_CONTROL, 8'h00);
    clear_flags();
    $display("test sleep done");
  endtask
  task automatic t_rerst();
    @(posedge clock);
    reset <= 1'b1;
    repeat (3) @(posedge clock);
    reset <= 1'b0;
    rdc(ADDR_COMPARATOR_CONTROL, RST_COMPARATOR_CONTROL);
    rdc(ADDR_LADDER_CONTROL, RST_LADDER_CONTROL);
    $display("test second reset done");
  endtask
  initial begin
    repeat (16) @(posedge clock);
    reset <= 1'b0;
    t_reset();
    t_ladder();
    t_modes();
    t_change();
    t_sleep();
    t_rerst();
    conclude();
  end
endmodule
`default_nettype wire
